// ===== inc/ecglf_regs.svh
// Register offsets, field positions, reset values and timing counts of the lead formation block.
`ifndef ECGLF_REGS_SVH
`define ECGLF_REGS_SVH
`define ECGLF_CHCTL_IDX      8'h01
`define ECGLF_CMCTL_IDX      8'h05
`define ECGLF_FRAME_CONTROL_REG_IDX     8'h0a
`define ECGLF_CHCTL_ADDR     (`ECGLF_CHCTL_IDX * 8'h04)
`define ECGLF_CMCTL_ADDR     (`ECGLF_CMCTL_IDX * 8'h04)
`define ECGLF_FRAME_CONTROL_REG_ADDR    (`ECGLF_FRAME_CONTROL_REG_IDX * 8'h04)
`define ECGLF_OVR_ADDR       8'h40
`define ECGLF_UND_ADDR       8'h44
`define ECGLF_HDR_ADDR       8'h48
`define ECGLF_WORD0_ADDR     8'h4c
`define ECGLF_ISTAT_ADDR     8'h60
`define ECGLF_IMASK_ADDR     8'h64
`define ECGLF_RATE_ADDR      8'h68
`define ECGLF_DIFF_BIT       10
`define ECGLF_CE_BIT         8
`define ECGLF_FMT_BIT        4
`define ECGLF_HDR_OOR_BIT    0
`define ECGLF_HDR_LEAD_BIT   1
`define ECGLF_IRQ_FRAME_BIT  0
`define ECGLF_IRQ_OOR_BIT    1
`define ECGLF_IRQ_REFUSE_BIT 2
`define ECGLF_OVR_RESET      14'h3f00
`define ECGLF_UND_RESET      14'h0100
`define ECGLF_CLK_HZ         50000000
`define ECGLF_ADC_HZ         2000000
`define ECGLF_ADC_DIV        (`ECGLF_CLK_HZ / `ECGLF_ADC_HZ)
`define ECGLF_OSR            1024
// The 1.3 V level on a 3.6 V full scale, at the scale of a 1024 sample sum.
`define ECGLF_REF_CODE       26'sd6058485
`endif

// ===== inc/ecglf_pkg.sv
// Types shared by the lead formation block.
package ecglf_pkg;
  typedef enum logic [2:0] {
    ECGLF_ANALOG  = 3'h0,
    ECGLF_DIGITAL = 3'h1,
    ECGLF_SE_ELEC = 3'h3,
    ECGLF_CE_A    = 3'h2,
    ECGLF_CE_B    = 3'h6,
    ECGLF_UNDEF   = 3'h7
  } ecglf_mode_t;
  typedef enum logic [1:0] {
    ECGLF_R2K   = 2'h0,
    ECGLF_R16K  = 2'h1,
    ECGLF_R128K = 2'h2
  } ecglf_rate_t;
endpackage

// ===== verilog/ecglf_decim.sv
// Oversampling accumulator of one converter channel.
`timescale 1ns/10ps
module ecglf_decim (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Samples
  input  wire logic        en_in,
  input  wire logic        dump_in,
  input  wire logic [13:0] sample_in,
  // Result
  output logic      [23:0] sum_out
);
  logic [23:0] acc;
  logic [23:0] next_acc;

  assign next_acc = acc + {10'h000, sample_in};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc     <= 24'h000000;
      sum_out <= 24'h000000;
    end else if (en_in) begin
      if (dump_in) begin
        sum_out <= next_acc;
        acc     <= 24'h000000;
      end else begin
        acc <= next_acc;
      end
    end
  end
endmodule

// ===== verilog/ecglf_range.sv
// Out of range detector of one converter channel, held for one output frame.
`timescale 1ns/10ps
module ecglf_range (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Samples and thresholds
  input  wire logic        en_in,
  input  wire logic        dump_in,
  input  wire logic [13:0] sample_in,
  input  wire logic [13:0] over_in,
  input  wire logic [13:0] under_in,
  // Result
  output logic             flag_out
);
  logic hit;
  logic now_out;

  assign now_out = (sample_in > over_in) || (sample_in < under_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hit      <= 1'b0;
      flag_out <= 1'b0;
    end else if (en_in) begin
      if (dump_in) begin
        flag_out <= hit | now_out;
        hit      <= 1'b0;
      end else begin
        hit <= hit | now_out;
      end
    end
  end
endmodule

// ===== verilog/ecglf_top.sv
// Lead and electrode formation of a five channel ECG front end with an AHB-Lite register slave.
//
// Notes on behaviour
// - Frame control bit 4 chooses lead words when 0 and electrode words when 1.
// - Channel control bit 10 chooses differential inputs when 1 and single ended when 0.
// - Common mode control bit 8 enables the shared reference electrode.
// - Analog lead mode gives LA-RA, LL-RA, LL-LA, V1 and V2 against common mode.
// - Analog lead mode negates the second word to undo the analog inversion.
// - Digital lead mode computes the three leads and V1, V2 against the limb average.
// - Digital lead mode needs common mode control bit 8 clear (set gives common electrode A) and ignores the other bits.
// - Digital leads are only produced at 2 kHz and 16 kHz output rates.
// - Single ended electrode mode gives LA, LL, RA, V1 and V2 against common mode.
// - Common electrode A corrects V3, V1 and V2 by a third of both leads.
// - Common electrode B gives LA, LL, V1, V2 and V3 against the shared electrode.
// - The 1.3 V reference level is removed from every output word.
// - Each channel is sampled at 2 MHz and summed over 1024 samples at 2 kHz, 128 at 16 kHz and 16 at 128 kHz.
// - Samples beyond the programmed thresholds raise the header out of range flag.
// - At 128 kHz digital lead mode is refused and gives single ended electrode words with the header lead flag clear.
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ecglf_regs.svh"
module ecglf_top (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        NRST_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // Converter channels
  output logic             ADC_CONV_OUT,
  input  wire logic [13:0] ADC_CH0_IN,
  input  wire logic [13:0] ADC_CH1_IN,
  input  wire logic [13:0] ADC_CH2_IN,
  input  wire logic [13:0] ADC_CH3_IN,
  input  wire logic [13:0] ADC_CH4_IN,
  // Frame and interrupt
  output logic             FRAME_STB_OUT,
  output logic             IRQ_OUT
);
  import ecglf_pkg::*;

  logic               rst_meta;
  logic               rst_n;
  logic [4:0]         adc_div;
  logic               adc_tick;
  logic [9:0]         samp_cnt;
  logic [9:0]         samp_last;
  logic               dump;
  logic               pipe;
  logic [13:0]        adc_in [5];
  logic [23:0]        sum [5];
  logic [23:0]        scaled [5];
  logic               oor [5];
  logic signed [25:0] elec [5];
  logic signed [25:0] next_word [5];
  logic signed [25:0] word [5];
  logic signed [27:0] limb_sum;
  logic signed [27:0] lead_sum;
  logic signed [25:0] limb_average_reference;
  logic signed [25:0] cea;
  logic [31:0]        ch_ctl;
  logic [31:0]        cm_ctl;
  logic [31:0]        frm_ctl;
  logic [13:0]        ovr;
  logic [13:0]        und;
  logic [1:0]         rate;
  logic [31:0]        imask;
  logic [2:0]         istat;
  logic [2:0]         set_ev;
  logic [2:0]         clr_ev;
  logic [1:0]         header;
  ecglf_rate_t        eff_rate;
  ecglf_mode_t        mode;
  ecglf_mode_t        eff_mode;
  logic               refused;
  logic               addr_take;
  logic               wr_pend;
  logic [7:0]         wr_addr;
  logic [31:0]        rd_mux;

  // Reset release through two flip-flops.
  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      adc_div <= 5'h00;
    end else if (adc_div == 5'(`ECGLF_ADC_DIV - 1)) begin
      adc_div <= 5'h00;
    end else begin
      adc_div <= adc_div + 5'h01;
    end
  end
  assign adc_tick     = (adc_div == 5'h00);
  assign ADC_CONV_OUT = adc_tick;

  always_comb begin
    unique case (rate)
      2'h1:    eff_rate = ECGLF_R16K;
      2'h2:    eff_rate = ECGLF_R128K;
      default: eff_rate = ECGLF_R2K;
    endcase
  end

  assign samp_last = 10'(`ECGLF_OSR - 1) >> (4'h3 * {2'h0, eff_rate});
  assign dump      = adc_tick && (samp_cnt >= samp_last);
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt <= 10'h000;
    end else if (adc_tick) begin
      samp_cnt <= dump ? 10'h000 : samp_cnt + 10'h001;
    end
  end

  assign adc_in[0] = ADC_CH0_IN;
  assign adc_in[1] = ADC_CH1_IN;
  assign adc_in[2] = ADC_CH2_IN;
  assign adc_in[3] = ADC_CH3_IN;
  assign adc_in[4] = ADC_CH4_IN;

  for (genvar i = 0; i < 5; i++) begin : g_ch
    ecglf_decim u_decim (
      .clk_in    (CLK_IN),
      .rst_n_in  (rst_n),
      .en_in     (adc_tick),
      .dump_in   (dump),
      .sample_in (adc_in[i]),
      .sum_out   (sum[i])
    );
    ecglf_range u_range (
      .clk_in    (CLK_IN),
      .rst_n_in  (rst_n),
      .en_in     (adc_tick),
      .dump_in   (dump),
      .sample_in (adc_in[i]),
      .over_in   (ovr),
      .under_in  (und),
      .flag_out  (oor[i])
    );
    assign scaled[i] = (eff_rate == ECGLF_R128K) ? {sum[i][17:0], 6'h00} :
                       (eff_rate == ECGLF_R16K)  ? {sum[i][20:0], 3'h0} : sum[i];
    assign elec[i] = $signed({2'b00, scaled[i]}) - `ECGLF_REF_CODE;
  end

  always_comb begin
    unique case ({frm_ctl[`ECGLF_FMT_BIT], ch_ctl[`ECGLF_DIFF_BIT], cm_ctl[`ECGLF_CE_BIT]})
      3'b010:  mode = ECGLF_ANALOG;
      3'b000:  mode = ECGLF_DIGITAL;
      3'b100:  mode = ECGLF_SE_ELEC;
      3'b001:  mode = ECGLF_CE_A;
      3'b101:  mode = ECGLF_CE_B;
      default: mode = ECGLF_UNDEF;
    endcase
  end

  // no digital leads at 128 kHz
  assign refused  = (mode == ECGLF_DIGITAL) && (eff_rate == ECGLF_R128K);
  assign eff_mode = refused ? ECGLF_SE_ELEC : mode;

  assign limb_sum = 28'(elec[0]) + 28'(elec[1]) + 28'(elec[2]);
  assign limb_average_reference      = 26'(limb_sum / 28'sd3);
  assign lead_sum = 28'(elec[0]) + 28'(elec[1]);
  assign cea      = 26'(lead_sum / 28'sd3);

  always_comb begin
    for (int k = 0; k < 5; k++) begin
      next_word[k] = elec[k];
    end
    unique case (eff_mode)
      ECGLF_ANALOG: begin
        next_word[1] = -elec[1];
      end
      ECGLF_DIGITAL: begin
        next_word[0] = elec[0] - elec[2];
        next_word[1] = elec[1] - elec[2];
        next_word[2] = elec[1] - elec[0];
        next_word[3] = elec[3] - limb_average_reference;
        next_word[4] = elec[4] - limb_average_reference;
      end
      ECGLF_CE_A: begin
        next_word[2] = elec[2] - cea;
        next_word[3] = elec[3] - cea;
        next_word[4] = elec[4] - cea;
      end
      ECGLF_CE_B: begin
        next_word[2] = elec[3];
        next_word[3] = elec[4];
        next_word[4] = elec[2];
      end
      default: begin
        next_word[0] = elec[0];
      end
    endcase
  end

  // Words and header latch one cycle after the sums settle.
  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      pipe          <= 1'b0;
      FRAME_STB_OUT <= 1'b0;
      header        <= 2'h0;
      for (int k = 0; k < 5; k++) begin
        word[k] <= 26'sd0;
      end
    end else begin
      pipe          <= dump;
      FRAME_STB_OUT <= pipe;
      if (pipe) begin
        header[`ECGLF_HDR_OOR_BIT]  <= oor[0] | oor[1] | oor[2] | oor[3] | oor[4];
        header[`ECGLF_HDR_LEAD_BIT] <= !frm_ctl[`ECGLF_FMT_BIT] && !refused;
        for (int k = 0; k < 5; k++) begin
          word[k] <= next_word[k];
        end
      end
    end
  end

  // AHB-Lite slave with no wait states.
  assign addr_take     = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  always_comb begin
    rd_mux = 32'h00000000;
    if (HADDR_IN[31:8] == 24'h000000) begin
      unique case (HADDR_IN[7:0])
        `ECGLF_CHCTL_ADDR:        rd_mux = ch_ctl;
        `ECGLF_CMCTL_ADDR:        rd_mux = cm_ctl;
        `ECGLF_FRAME_CONTROL_REG_ADDR:       rd_mux = frm_ctl;
        `ECGLF_OVR_ADDR:          rd_mux = {18'h00000, ovr};
        `ECGLF_UND_ADDR:          rd_mux = {18'h00000, und};
        `ECGLF_HDR_ADDR:          rd_mux = {30'h00000000, header};
        `ECGLF_WORD0_ADDR:        rd_mux = 32'(word[0]);
        `ECGLF_WORD0_ADDR + 8'h4: rd_mux = 32'(word[1]);
        `ECGLF_WORD0_ADDR + 8'h8: rd_mux = 32'(word[2]);
        `ECGLF_WORD0_ADDR + 8'hc: rd_mux = 32'(word[3]);
        `ECGLF_WORD0_ADDR + 8'h10: rd_mux = 32'(word[4]);
        `ECGLF_ISTAT_ADDR:        rd_mux = {29'h00000000, istat};
        `ECGLF_IMASK_ADDR:        rd_mux = {29'h00000000, imask[2:0]};
        `ECGLF_RATE_ADDR:         rd_mux = {30'h00000000, rate};
        default:                  rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA_OUT <= 32'h00000000;
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
    end else begin
      wr_pend <= addr_take && HWRITE_IN && (HADDR_IN[31:8] == 24'h000000);
      wr_addr <= HADDR_IN[7:0];
      if (addr_take && !HWRITE_IN) begin
        HRDATA_OUT <= rd_mux;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ch_ctl  <= 32'h00000000;
      cm_ctl  <= 32'h00000000;
      frm_ctl <= 32'h00000000;
      ovr     <= `ECGLF_OVR_RESET;
      und     <= `ECGLF_UND_RESET;
      rate    <= 2'h0;
      imask   <= 32'h00000000;
    end else if (wr_pend) begin
      unique case (wr_addr)
        `ECGLF_CHCTL_ADDR:  ch_ctl  <= HWDATA_IN;
        `ECGLF_CMCTL_ADDR:  cm_ctl  <= HWDATA_IN;
        `ECGLF_FRAME_CONTROL_REG_ADDR: frm_ctl <= HWDATA_IN;
        `ECGLF_OVR_ADDR:    ovr     <= HWDATA_IN[13:0];
        `ECGLF_UND_ADDR:    und     <= HWDATA_IN[13:0];
        `ECGLF_IMASK_ADDR:  imask   <= {29'h00000000, HWDATA_IN[2:0]};
        `ECGLF_RATE_ADDR:   rate    <= HWDATA_IN[1:0];
        default:            rate    <= rate;
      endcase
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  assign set_ev[`ECGLF_IRQ_FRAME_BIT]  = pipe;
  assign set_ev[`ECGLF_IRQ_OOR_BIT]    = pipe && (oor[0] | oor[1] | oor[2] | oor[3] | oor[4]);
  assign set_ev[`ECGLF_IRQ_REFUSE_BIT] = pipe && refused;
  assign clr_ev = (wr_pend && wr_addr == `ECGLF_ISTAT_ADDR) ? HWDATA_IN[2:0] : 3'h0;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      istat <= 3'h0;
    end else begin
      istat <= (istat & ~clr_ev) | set_ev;
    end
  end
  assign IRQ_OUT = |(istat & imask[2:0]);

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!rst_n);

  property p_fmt_elec;
    pipe && eff_mode == ECGLF_SE_ELEC |=> word[2] == $past(elec[2]);
  endproperty
  a_fmt_elec: assert property (p_fmt_elec) else $error("electrode word wrong");

  property p_analog_inv;
    pipe && mode == ECGLF_ANALOG |=> word[1] == -$past(elec[1]) && word[0] == $past(elec[0]);
  endproperty
  a_analog_inv: assert property (p_analog_inv) else $error("analog lead sign");

  property p_digital_v1;
    pipe && eff_mode == ECGLF_DIGITAL |=> word[3] == $past(elec[3] - limb_average_reference);
  endproperty
  a_digital_v1: assert property (p_digital_v1) else $error("digital V1 wrong");

  property p_digital_lead;
    pipe && eff_mode == ECGLF_DIGITAL |=> word[2] == $past(elec[1] - elec[0]);
  endproperty
  a_digital_lead: assert property (p_digital_lead) else $error("digital lead wrong");

  property p_ce_a;
    pipe && mode == ECGLF_CE_A |=> word[4] == $past(elec[4] - cea);
  endproperty
  a_ce_a: assert property (p_ce_a) else $error("common A wrong");

  property p_ce_b;
    pipe && mode == ECGLF_CE_B |=> word[4] == $past(elec[2]) && word[2] == $past(elec[3]);
  endproperty
  a_ce_b: assert property (p_ce_b) else $error("common B order");

  property p_ref_removed;
    pipe && mode == ECGLF_SE_ELEC |=> word[0] + `ECGLF_REF_CODE == $signed({2'b00, $past(scaled[0])});
  endproperty
  a_ref_removed: assert property (p_ref_removed) else $error("reference kept");

  property p_tick_period;
    adc_tick |-> ##1 !adc_tick [*8] ##17 adc_tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period");

  property p_oor_hdr;
    pipe && (oor[0] | oor[1] | oor[2] | oor[3] | oor[4]) |=> header[0] && istat[1];
  endproperty
  a_oor_hdr: assert property (p_oor_hdr) else $error("range flag lost");

  property p_refuse;
    pipe && mode == ECGLF_DIGITAL && eff_rate == ECGLF_R128K |=> istat[2] && !header[1];
  endproperty
  a_refuse: assert property (p_refuse) else $error("digital at 128k");

  c_analog: cover property (pipe && mode == ECGLF_ANALOG);
  c_digital: cover property (pipe && mode == ECGLF_DIGITAL && !refused);
  c_ce_b: cover property (pipe && mode == ECGLF_CE_B);
  c_irq: cover property (IRQ_OUT && oor[0]);
endmodule

// ===== verilog/ecglf_unused_placeholder_none.sv
// Intentionally empty compile unit.
`timescale 1ns/10ps

// ===== tb/ecglf_adc_model.sv
// Electrode channel model that answers each converter strobe of the device.
`timescale 1ns/10ps
module ecglf_adc_model (
  // Strobe from the device
  input  wire logic        conv_in,
  // Electrode levels chosen by the bench
  input  wire logic [13:0] code0_in,
  input  wire logic [13:0] code1_in,
  input  wire logic [13:0] code2_in,
  input  wire logic [13:0] code3_in,
  input  wire logic [13:0] code4_in,
  // Converter codes to the device
  output logic      [13:0] ch0_out,
  output logic      [13:0] ch1_out,
  output logic      [13:0] ch2_out,
  output logic      [13:0] ch3_out,
  output logic      [13:0] ch4_out
);
  // one code per strobe
  // Outside the strobe the lines show the inverse, so a stray sample is wrong.
  assign ch0_out = conv_in ? code0_in : ~code0_in;
  assign ch1_out = conv_in ? code1_in : ~code1_in;
  assign ch2_out = conv_in ? code2_in : ~code2_in;
  assign ch3_out = conv_in ? code3_in : ~code3_in;
  assign ch4_out = conv_in ? code4_in : ~code4_in;
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the lead formation block with its electrode model.
`timescale 1ns/10ps
`include "ecglf_regs.svh"
module tb_top;
  logic        clk;
  logic        nrst;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [13:0] code [5];
  logic [2:0]  mt [4];
  wire  [31:0] hrdata;
  wire         hready;
  wire         conv;
  wire         fstb;
  wire         irq;
  wire         hresp;
  wire  [13:0] ch [5];
  int          err_count;
  int          num_checks;
  int          k;
  int          e [5];
  int          x [5];

  ecglf_top dut (
    .CLK_IN        (clk),
    .NRST_IN       (nrst),
    .HSEL_IN       (hsel),
    .HADDR_IN      (haddr),
    .HTRANS_IN     (htrans),
    .HWRITE_IN     (hwrite),
    .HSIZE_IN      (hsize),
    .HWDATA_IN     (hwdata),
    .HREADY_IN     (hready),
    .HRDATA_OUT    (hrdata),
    .HREADYOUT_OUT (hready),
    .HRESP_OUT     (hresp),
    .ADC_CONV_OUT  (conv),
    .ADC_CH0_IN    (ch[0]),
    .ADC_CH1_IN    (ch[1]),
    .ADC_CH2_IN    (ch[2]),
    .ADC_CH3_IN    (ch[3]),
    .ADC_CH4_IN    (ch[4]),
    .FRAME_STB_OUT (fstb),
    .IRQ_OUT       (irq)
  );

  ecglf_adc_model model (
    .conv_in  (conv),
    .code0_in (code[0]),
    .code1_in (code[1]),
    .code2_in (code[2]),
    .code3_in (code[3]),
    .code4_in (code[4]),
    .ch0_out  (ch[0]),
    .ch1_out  (ch[1]),
    .ch2_out  (ch[2]),
    .ch3_out  (ch[3]),
    .ch4_out  (ch[4])
  );

  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr_en, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr_en;
    haddr  <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  task automatic span(input logic f, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((f ? fstb : conv) !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      err_count++;
      $display("[ERR] %0t strobe never came", $time);
    end
  endtask

  task automatic frames(input int n);
    int m;
    repeat (n) span(1'b1, m);
  endtask

  task automatic set_mode(input logic f, input logic d, input logic c, input logic [31:0] extra);
    wr(`ECGLF_FRAME_CONTROL_REG_ADDR, 32'(f) << `ECGLF_FMT_BIT);
    wr(`ECGLF_CHCTL_ADDR, 32'(d) << `ECGLF_DIFF_BIT);
    wr(`ECGLF_CMCTL_ADDR, (32'(c) << `ECGLF_CE_BIT) | extra);
    rchk(`ECGLF_FRAME_CONTROL_REG_ADDR, 32'(f) << `ECGLF_FMT_BIT);
    rchk(`ECGLF_CHCTL_ADDR, 32'(d) << `ECGLF_DIFF_BIT);
    rchk(`ECGLF_CMCTL_ADDR, (32'(c) << `ECGLF_CE_BIT) | extra);
  endtask

  task automatic expect_words(input int m);
    int c;
    int w;
    for (int i = 0; i < 5; i++) begin
      e[i] = `ECGLF_OSR * int'(code[i]) - int'(`ECGLF_REF_CODE);
    end
    c = (e[0] + e[1]) / 3;
    w = (e[0] + e[1] + e[2]) / 3;
    case (m)
      0: x = '{e[0], -e[1], e[2], e[3], e[4]};
      1: x = '{e[0], e[1], e[2], e[3], e[4]};
      2: x = '{e[0], e[1], e[2] - c, e[3] - c, e[4] - c};
      3: x = '{e[0], e[1], e[3], e[4], e[2]};
      default: x = '{e[0] - e[2], e[1] - e[2], e[1] - e[0], e[3] - w, e[4] - w};
    endcase
    for (int i = 0; i < 5; i++) begin
      rchk(`ECGLF_WORD0_ADDR + 4 * i, x[i]);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    clk        = 1'b0;
    nrst       = 1'b0;
    hsel       = 1'b0;
    hwrite     = 1'b0;
    htrans     = 2'h0;
    hsize      = 3'h2;
    haddr      = 32'h0;
    hwdata     = 32'h0;
    err_count  = 0;
    num_checks = 0;
    code       = '{14'h1770, 14'h1838, 14'h16a8, 14'h1964, 14'h157c};
    mt         = '{3'h2, 3'h4, 3'h1, 3'h5};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`ECGLF_CHCTL_ADDR, 32'h0);
    rchk(`ECGLF_CMCTL_ADDR, 32'h0);
    rchk(`ECGLF_FRAME_CONTROL_REG_ADDR, 32'h0);
    rchk(`ECGLF_OVR_ADDR, 32'(`ECGLF_OVR_RESET));
    rchk(`ECGLF_UND_ADDR, 32'(`ECGLF_UND_RESET));
    rchk(`ECGLF_IMASK_ADDR, 32'h0);
    rchk(`ECGLF_RATE_ADDR, 32'h0);
    wr(32'h100, 32'hffffffff);
    rchk(32'h100, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    span(1'b0, k);
    span(1'b0, k);
    chk(k, `ECGLF_ADC_DIV);
    $display("test registers and strobe done");
    frames(1);
    expect_words(4);
    rchk(`ECGLF_HDR_ADDR, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(`ECGLF_RATE_ADDR, 32'h1);
    set_mode(1'b0, 1'b0, 1'b0, 32'hff);
    frames(2);
    expect_words(4);
    $display("test digital leads done");
    wr(`ECGLF_RATE_ADDR, 32'h2);
    for (int m = 0; m < 4; m++) begin
      set_mode(mt[m][2], mt[m][1], mt[m][0], 32'h0);
      frames(2);
      expect_words(m);
      if (m < 2) begin
        rchk(`ECGLF_HDR_ADDR, (m == 0) ? 32'h2 : 32'h0);
      end
    end
    span(1'b1, k);
    span(1'b1, k);
    chk(k, 16 * `ECGLF_ADC_DIV);
    $display("test modes at 128k done");
    set_mode(1'b0, 1'b0, 1'b0, 32'h0);
    wr(`ECGLF_IMASK_ADDR, 32'h4);
    frames(2);
    expect_words(1);
    rchk(`ECGLF_HDR_ADDR, 32'h0);
    rchk(`ECGLF_ISTAT_ADDR, 32'h5);
    chk({31'h0, irq}, 32'h1);
    frames(1);
    wr(`ECGLF_ISTAT_ADDR, 32'h7);
    rchk(`ECGLF_ISTAT_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test digital refusal done");
    set_mode(1'b1, 1'b0, 1'b0, 32'h0);
    wr(`ECGLF_IMASK_ADDR, 32'h2);
    code[3] <= 14'h3f80;
    frames(2);
    rchk(`ECGLF_HDR_ADDR, 32'h1);
    chk({31'h0, irq}, 32'h1);
    code[3] <= 14'h1964;
    wr(`ECGLF_UND_ADDR, 32'h1800);
    frames(2);
    rchk(`ECGLF_HDR_ADDR, 32'h1);
    wr(`ECGLF_UND_ADDR, 32'(`ECGLF_UND_RESET));
    frames(2);
    rchk(`ECGLF_HDR_ADDR, 32'h0);
    wr(`ECGLF_ISTAT_ADDR, 32'h7);
    rchk(`ECGLF_ISTAT_ADDR, 32'h0);
    chk({31'h0, irq}, 32'h0);
    expect_words(1);
    $display("test out of range done");
    report_and_stop();
  end
endmodule
